// ===== nva_pkg.sv
// Constants, field layout and bus carrier for the data EEPROM access control
// ==========================================================================
// How it works
// - Mode 00 erase+write (3.4ms), 01 erase only, 10 write only, 11 reserved.
// - Mode field writes are ignored while the write strobe is set.
// - System reset clears the mode field unless programming is still running.
// - Ready interrupt needs enable bit one and the global flag set.
// - Ready request stands while strobe clear; never during write or self-program.
// - Master write enable clears itself four clocks after software sets it.
// - Strobe starts programming only while master enable is still one.
// - Write strobe clears by itself when the programming time has elapsed.
// - Setting the write strobe stalls the processor for two cycles.
// - Read strobe loads the addressed byte into the data register at once.
// - A read strobe stalls the processor for four cycles.
// - During a write, reads are refused and the address register is frozen.
// - Erase+write is timed by counting 26,368 calibrated oscillator cycles; erase only and write only count 13,959.
// - Address register is nine bits, selecting one of 512 bytes.
// - Data register supplies write data and receives read data.
// - A system reset during a write lets that write finish; power-on reset stops it.
package nva_pkg;

  // ========================================================================
  // Register offsets (data-space view)
  localparam logic [7:0] NVA_OFS_CTRL = 8'h3f;
  localparam logic [7:0] NVA_OFS_DATA = 8'h40;
  localparam logic [7:0] NVA_OFS_ADDRL = 8'h41;
  localparam logic [7:0] NVA_OFS_ADDRH = 8'h42;

  // ========================================================================
  // Control register fields
  localparam int NVA_BIT_READ = 0;
  localparam int NVA_BIT_STROBE = 1;
  localparam int NVA_BIT_MWE = 2;
  localparam int NVA_BIT_RIE = 3;
  localparam int NVA_BIT_MODE_LO = 4;
  localparam int NVA_BIT_MODE_HI = 5;

  // ========================================================================
  // Reset values and counts
  localparam logic [1:0] NVA_MODE_RESET = 2'h0;
  localparam logic [7:0] NVA_DATA_RESET = 8'h00;
  localparam logic [8:0] NVA_ADDR_RESET = 9'h000;
  localparam logic [2:0] NVA_MWE_CYCLES = 3'h4;
  localparam logic [2:0] NVA_WR_STALL = 3'h2;
  localparam logic [2:0] NVA_RD_STALL = 3'h4;
  localparam int NVA_MEM_BYTES = 512;
  localparam logic [7:0] NVA_ERASED = 8'hff;
  // Programming times in microseconds, and oscillator ticks for each
  localparam int NVA_T_FULL_US = 3400;
  localparam int NVA_T_HALF_US = 1800;
  localparam int NVA_TICKS_FULL = 26368;
  localparam int NVA_TICKS_HALF = NVA_TICKS_FULL * NVA_T_HALF_US / NVA_T_FULL_US;

  typedef enum logic [1:0] {
    NVA_PM_ATOMIC = 2'h0,
    NVA_PM_ERASE = 2'h1,
    NVA_PM_WRITE = 2'h2,
    NVA_PM_RSVD = 2'h3
  } nva_mode_t;

  // One processor I/O access, valid for the cycle in which wr or rd is high
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nva_io_t;

endpackage

// ===== nva_access_ctrl.sv
// Data EEPROM access control: registers, programming timer, stall and ready request
module nva_access_ctrl #(
  parameter int PROG_TICKS_FULL = nva_pkg::NVA_TICKS_FULL,
  parameter int PROG_TICKS_HALF = nva_pkg::NVA_TICKS_HALF
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic por_n,
  // Processor I/O port
  input wire nva_pkg::nva_io_t io_req,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  // Core status
  input wire logic global_irq_flag,
  input wire logic self_program_busy,
  // Calibrated oscillator, asynchronous to ref_clk
  input wire logic rc_osc,
  // Interrupt request
  output logic ready_irq
);
  import nva_pkg::*;

  // ========================================================================
  // Storage
  logic [7:0] mem [NVA_MEM_BYTES];

  // Engine state survives the system reset so a running write can finish
  logic busy_reg, busy_next;
  logic [1:0] mode_reg, mode_next;
  logic [14:0] tick_reg, tick_next;
  logic [8:0] pa_reg, pa_next;
  logic [7:0] pd_reg, pd_next;
  logic osc_meta, osc_sync, osc_prev;
  logic rst_meta, rst_sync;

  // Software-facing state, cleared by the system reset
  logic rie_reg, rie_next;
  logic mwe_reg, mwe_next;
  logic [2:0] mwe_cnt_reg, mwe_cnt_next;
  logic [8:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;
  logic [2:0] stall_reg, stall_next;
  logic stall_out_reg, stall_out_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;

  logic wr_ctrl, start_wr, rd_go, tick, done;
  logic [14:0] ticks_needed;

  // ========================================================================
  // Synchronisers
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      osc_meta <= rc_osc;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      rst_meta <= reset_n;
      rst_sync <= rst_meta;
    end
  end

  assign tick = osc_sync & ~osc_prev;
  assign wr_ctrl = io_req.wr && (io_req.addr == NVA_OFS_CTRL);
  // Reserved mode starts nothing, so software cannot launch an undefined cycle
  assign start_wr = wr_ctrl && io_req.wdata[NVA_BIT_STROBE] && mwe_reg && !busy_reg
    && (io_req.wdata[NVA_BIT_MODE_HI:NVA_BIT_MODE_LO] != NVA_PM_RSVD);
  assign rd_go = wr_ctrl && io_req.wdata[NVA_BIT_READ] && !busy_reg;
  assign ticks_needed = (mode_reg == NVA_PM_ATOMIC) ? PROG_TICKS_FULL[14:0]
    : PROG_TICKS_HALF[14:0];
  assign done = busy_reg && tick && (tick_reg == ticks_needed - 15'h0001);

  // ========================================================================
  // Programming engine
  always_comb begin
    busy_next = busy_reg;
    mode_next = mode_reg;
    tick_next = tick_reg;
    pa_next = pa_reg;
    pd_next = pd_reg;
    if (wr_ctrl && !busy_reg) begin
      mode_next = io_req.wdata[NVA_BIT_MODE_HI:NVA_BIT_MODE_LO];
    end
    if (!rst_sync && !busy_reg) begin
      mode_next = NVA_MODE_RESET;
    end
    if (start_wr) begin
      busy_next = 1'b1;
      tick_next = 15'h0000;
      pa_next = addr_reg;
      pd_next = data_reg;
    end else if (busy_reg && tick) begin
      tick_next = tick_reg + 15'h0001;
      if (done) begin
        busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      busy_reg <= 1'b0;
      mode_reg <= NVA_MODE_RESET;
      tick_reg <= 15'h0000;
      pa_reg <= NVA_ADDR_RESET;
      pd_reg <= NVA_DATA_RESET;
    end else begin
      busy_reg <= busy_next;
      mode_reg <= mode_next;
      tick_reg <= tick_next;
      pa_reg <= pa_next;
      pd_reg <= pd_next;
    end
  end

  // Array update at the end of the cycle; write-only can only clear bits
  always_ff @(posedge ref_clk) begin
    if (done) begin
      case (mode_reg)
        NVA_PM_ATOMIC: mem[pa_reg] <= pd_reg;
        NVA_PM_ERASE: mem[pa_reg] <= NVA_ERASED;
        NVA_PM_WRITE: mem[pa_reg] <= mem[pa_reg] & pd_reg;
        default: mem[pa_reg] <= mem[pa_reg];
      endcase
    end
  end

  // ========================================================================
  // Registers, stall and ready request
  always_comb begin
    rie_next = rie_reg;
    mwe_next = mwe_reg;
    mwe_cnt_next = mwe_cnt_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    stall_next = (stall_reg != 3'h0) ? stall_reg - 3'h1 : 3'h0;
    rdata_next = rdata_reg;
    if (mwe_reg) begin
      mwe_cnt_next = mwe_cnt_reg - 3'h1;
      if (mwe_cnt_reg == 3'h1) begin
        mwe_next = 1'b0;
      end
    end
    if (wr_ctrl) begin
      rie_next = io_req.wdata[NVA_BIT_RIE];
      if (io_req.wdata[NVA_BIT_MWE]) begin
        mwe_next = 1'b1;
        mwe_cnt_next = NVA_MWE_CYCLES;
      end
    end
    if (io_req.wr && io_req.addr == NVA_OFS_DATA) begin
      data_next = io_req.wdata;
    end
    if (io_req.wr && !busy_reg && io_req.addr == NVA_OFS_ADDRL) begin
      addr_next = {addr_reg[8], io_req.wdata};
    end
    if (io_req.wr && !busy_reg && io_req.addr == NVA_OFS_ADDRH) begin
      addr_next = {io_req.wdata[0], addr_reg[7:0]};
    end
    if (rd_go) begin
      data_next = mem[addr_reg];
      stall_next = NVA_RD_STALL;
    end else if (start_wr) begin
      stall_next = NVA_WR_STALL;
    end
    stall_out_next = (stall_next != 3'h0);
    if (io_req.rd) begin
      case (io_req.addr)
        NVA_OFS_CTRL: rdata_next = {2'b00, mode_reg, rie_reg, mwe_reg, busy_reg, 1'b0};
        NVA_OFS_DATA: rdata_next = data_reg;
        NVA_OFS_ADDRL: rdata_next = addr_reg[7:0];
        NVA_OFS_ADDRH: rdata_next = {7'h00, addr_reg[8]};
        default: rdata_next = 8'h00;
      endcase
    end
    irq_next = rie_reg && global_irq_flag && !busy_reg && !self_program_busy;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rie_reg <= 1'b0;
      mwe_reg <= 1'b0;
      mwe_cnt_reg <= 3'h0;
      addr_reg <= NVA_ADDR_RESET;
      data_reg <= NVA_DATA_RESET;
      stall_reg <= 3'h0;
      stall_out_reg <= 1'b0;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      rie_reg <= rie_next;
      mwe_reg <= mwe_next;
      mwe_cnt_reg <= mwe_cnt_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      stall_reg <= stall_next;
      stall_out_reg <= stall_out_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  // Stall has its own flop so the core sees a glitch-free level, one cycle after the strobe
  assign cpu_stall = stall_out_reg;
  assign io_rdata = rdata_reg;
  assign ready_irq = irq_reg;

  // ========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n || !por_n);

  a_mwe_hold_four: assert property ($rose(mwe_reg) && !wr_ctrl |-> mwe_reg[*4])
    else $error("master enable dropped early");
  a_mwe_times_out: assert property (mwe_reg && mwe_cnt_reg == 3'h1 && !wr_ctrl
    |=> !mwe_reg)
    else $error("master enable did not time out");
  a_no_enable_no_start: assert property (wr_ctrl && !mwe_reg && !busy_reg |=> !busy_reg)
    else $error("write started without master enable");
  a_mode_locked: assert property (busy_reg |=> $stable(mode_reg))
    else $error("mode changed during programming");
  a_irq_gated: assert property (ready_irq |-> $past(rie_reg && global_irq_flag
    && !busy_reg && !self_program_busy))
    else $error("ready request without its conditions");
  a_wr_stall_two: assert property (start_wr |=> cpu_stall[*2] ##1 !cpu_stall)
    else $error("write stall length wrong");
  a_rd_stall_four: assert property (rd_go |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall length wrong");
  a_read_loads: assert property (rd_go |=> data_reg == $past(mem[addr_reg]))
    else $error("read data not loaded");
  a_addr_frozen: assert property (busy_reg && io_req.wr |=> $stable(addr_reg))
    else $error("address changed during write");
  a_strobe_clears: assert property (done |=> !busy_reg)
    else $error("strobe not cleared at end of write");

  c_write_start: cover property (start_wr);
  c_write_done: cover property (done);
  c_read: cover property (rd_go);
  c_irq: cover property ($rose(ready_irq));

endmodule // nva_access_ctrl

// ===== tb_eeprom_access_control.sv
// Self-checking testbench for the data EEPROM access control
module tb_eeprom_access_control;
  timeunit 1ns;
  timeprecision 1ps;
  import nva_pkg::*;
  // ==========================================================
  // Signals
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic por_n = 1'b0;
  nva_io_t io_req = '0;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic global_irq_flag = 1'b0;
  logic self_program_busy = 1'b0;
  logic rc_osc = 1'b0;
  logic ready_irq;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [8:0] a0;
  logic [7:0] d0;
  logic [7:0] d1;
  int seed;

  // Short programming counts keep the run brief
  nva_access_ctrl #(.PROG_TICKS_FULL(8), .PROG_TICKS_HALF(4)) u_nva_access_ctrl (
    .ref_clk(ref_clk), .reset_n(reset_n), .por_n(por_n), .io_req(io_req),
    .io_rdata(io_rdata), .cpu_stall(cpu_stall), .global_irq_flag(global_irq_flag),
    .self_program_busy(self_program_busy), .rc_osc(rc_osc), .ready_irq(ready_irq));

  // ==========================================================
  // Clocks, monitor and watchdog
  initial forever #10 ref_clk = ~ref_clk;
  // Oscillator period unrelated to the bus clock
  initial forever #37 rc_osc = ~rc_osc;
  always @(posedge ref_clk) rd_seen <= io_req.rd;
  always @(negedge ref_clk) begin
    if (rd_seen && exp_q.size() > 0) check("io_rdata", exp_q.pop_front(), io_rdata);
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      close_out();
    end
  end

  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Never issue while the core is held
  task automatic go();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (cpu_stall !== 1'b0 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic wr(logic [7:0] addr, logic [7:0] data);
    go();
    io_req.wr = 1'b1;
    io_req.addr = addr;
    io_req.wdata = data;
    @(negedge ref_clk);
    io_req.wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] addr, logic [7:0] exp);
    go();
    io_req.rd = 1'b1;
    io_req.addr = addr;
    exp_q.push_back(exp);
    @(negedge ref_clk);
    io_req.rd = 1'b0;
  endtask
  // Counts stalled cycles right after an access lands
  task automatic stall_chk(logic [7:0] exp);
    logic [7:0] cnt;
    cnt = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (cpu_stall !== 1'b0) cnt++;
      @(negedge ref_clk);
    end
    check("stall cycles", exp, cnt);
  endtask
  task automatic set_addr(logic [8:0] addr);
    wr(NVA_OFS_ADDRL, addr[7:0]);
    wr(NVA_OFS_ADDRH, {7'h00, addr[8]});
  endtask
  task automatic prog(logic [8:0] addr, logic [7:0] data, logic [1:0] mode, logic [7:0] ex);
    set_addr(addr);
    wr(NVA_OFS_DATA, data);
    wr(NVA_OFS_CTRL, 8'h04 | ex);
    wr(NVA_OFS_CTRL, {2'h0, mode, 4'h2} | ex);
  endtask
  task automatic rd_mem(logic [8:0] addr, logic [7:0] exp);
    set_addr(addr);
    wr(NVA_OFS_CTRL, 8'h01);
    rd(NVA_OFS_DATA, exp);
  endtask
  task automatic pulse_reset();
    @(negedge ref_clk);
    reset_n = 1'b0;
    @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = $urandom(32'h7b199c89);
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    por_n = 1'b1;
    rd(NVA_OFS_CTRL, 8'h00);
    rd(NVA_OFS_DATA, 8'h00);
    wr(NVA_OFS_CTRL, 8'hc0);
    rd(NVA_OFS_CTRL, 8'h00);
    $display("test reset values done");
    a0 = {1'b1, 8'($urandom)};
    d0 = 8'($urandom);
    prog(a0, d0, 2'h0, 8'h00);
    stall_chk(8'h02);
    rd(NVA_OFS_CTRL, 8'h02);
    wr(NVA_OFS_ADDRL, ~a0[7:0]);
    rd(NVA_OFS_ADDRL, a0[7:0]);
    wr(NVA_OFS_CTRL, 8'h01);
    stall_chk(8'h00);
    repeat (80) @(negedge ref_clk);
    rd(NVA_OFS_CTRL, 8'h00);
    wr(NVA_OFS_CTRL, 8'h01);
    stall_chk(8'h04);
    rd(NVA_OFS_DATA, d0);
    $display("test atomic write done");
    wr(NVA_OFS_CTRL, 8'h02);
    stall_chk(8'h00);
    wr(NVA_OFS_CTRL, 8'h04);
    rd(NVA_OFS_CTRL, 8'h04);
    repeat (4) @(negedge ref_clk);
    wr(NVA_OFS_CTRL, 8'h02);
    rd(NVA_OFS_CTRL, 8'h00);
    prog(a0, d0, 2'h3, 8'h00);
    repeat (4) @(negedge ref_clk);
    rd(NVA_OFS_CTRL, 8'h30);
    $display("test enable timeout done");
    a0 = {1'b0, 8'($urandom)};
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    prog(a0, 8'h00, 2'h1, 8'h00);
    repeat (60) @(negedge ref_clk);
    rd_mem(a0, NVA_ERASED);
    prog(a0, d0, 2'h2, 8'h00);
    wr(NVA_OFS_CTRL, 8'h10);
    rd(NVA_OFS_CTRL, 8'h22);
    repeat (60) @(negedge ref_clk);
    rd_mem(a0, d0);
    $display("test split modes done");
    prog(a0, d1, 2'h2, 8'h00);
    pulse_reset();
    rd(NVA_OFS_CTRL, 8'h22);
    repeat (60) @(negedge ref_clk);
    rd(NVA_OFS_CTRL, 8'h20);
    pulse_reset();
    rd(NVA_OFS_CTRL, 8'h00);
    rd_mem(a0, d0 & d1);
    $display("test reset during write done");
    global_irq_flag = 1'b1;
    wr(NVA_OFS_CTRL, 8'h08);
    repeat (3) @(negedge ref_clk);
    check("ready_irq", 8'h01, ready_irq);
    self_program_busy = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("ready_irq", 8'h00, ready_irq);
    self_program_busy = 1'b0;
    global_irq_flag = 1'b0;
    prog(a0, d0, 2'h0, 8'h08);
    global_irq_flag = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("ready_irq", 8'h00, ready_irq);
    repeat (80) @(negedge ref_clk);
    check("ready_irq", 8'h01, ready_irq);
    global_irq_flag = 1'b0;
    repeat (3) @(negedge ref_clk);
    check("ready_irq", 8'h00, ready_irq);
    global_irq_flag = 1'b1;
    wr(NVA_OFS_CTRL, 8'h00);
    repeat (3) @(negedge ref_clk);
    check("ready_irq", 8'h00, ready_irq);
    $display("test ready request done");
    repeat (4) @(negedge ref_clk);
    close_out();
  end
endmodule // tb_eeprom_access_control
